// ---- design/host_bus_unit.sv ----
// Shared-bus host interface unit: address and data phases, endian steering
`timescale 1ns/1ps
`default_nettype none
module host_bus_unit
  import host_bus_pkg::*;
(
  input  wire logic        sys_clk,         // System clock
  input  wire logic        rst_n,           // Sync reset, active low
  input  wire logic        bus_16bit,       // 1: 16-bit bus, 0: 8-bit
  input  wire logic        select_n,        // Chip select, active low
  input  wire logic        cmd_type,        // 1 address phase, 0 data
  input  wire logic        read_strobe_n,   // Read strobe, active low
  input  wire logic        write_strobe_n,  // Write strobe, active low
  input  wire logic [15:0] shared_bus_in,   // Shared lanes, input side
  output logic      [15:0] shared_bus_out,  // Shared lanes, driven data
  output logic             shared_bus_oe_n, // Lane enable, low drives
  input  wire logic        endian_strap,    // Strap level, 1 big endian
  input  wire logic [15:0] receive_pointer_config, // Config register
  input  wire logic        irq_pending,     // Internal interrupt pending
  output logic             irq_out_n,       // Interrupt, active low
  output logic             big_endian,      // Active byte order
  output logic      [7:0]  reg_addr,        // Latched register address
  output logic      [3:0]  reg_lane_en,     // Latched byte enables
  output logic             reg_wr_pulse,    // One-cycle register write
  output logic      [15:0] reg_wdata,       // Steered write data
  output logic             reg_rd_pulse,    // One-cycle register read
  input  wire logic [15:0] reg_rdata        // Register read data
);

  logic [3:0] sync_s;
  logic       cs_n_s, cmd_s, rd_n_s, wr_n_s;
  logic       rd_n_d_r, wr_n_d_r;
  bus_state_e st_r, st_nxt;
  logic [WR_CNT_W-1:0] wr_cnt_r;
  logic       cmd_lat_r;
  logic [7:0] addr_r;
  logic [3:0] lane_en_r;
  logic [15:0] rd_data_r;
  logic       strap_r, strap_taken_r;
  logic       wr_pulse_r, rd_pulse_r;
  logic [15:0] wdata_r, lanes_d1_r, lanes_d2_r, lanes_hold_r;

  // Control pins cross into the system clock domain first
  strobe_sync #(.WIDTH(4)) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({select_n, cmd_type, read_strobe_n, write_strobe_n}),
    .rst_val  (4'hF),
    .sync_out (sync_s)
  );
  assign cs_n_s = sync_s[3];
  assign cmd_s  = sync_s[2];
  assign rd_n_s = sync_s[1];
  assign wr_n_s = sync_s[0];

  // Lanes get the strobes' two-flop delay and keep the last value seen with
  // the write strobe low, so a capture at release still gets valid data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lanes_d1_r   <= DATA_RST;
      lanes_d2_r   <= DATA_RST;
      lanes_hold_r <= DATA_RST;
    end else begin
      lanes_d1_r   <= shared_bus_in;
      lanes_d2_r   <= lanes_d1_r;
      lanes_hold_r <= wr_n_s ? lanes_hold_r : lanes_d2_r;
    end
  end

  // Strobe edges; the falls are qualified by chip select, the rises are not
  wire rd_fall  = rd_n_d_r & ~rd_n_s & ~cs_n_s;
  wire wr_fall  = wr_n_d_r & ~wr_n_s & ~cs_n_s;
  wire rd_rise  = ~rd_n_d_r & rd_n_s;
  wire wr_rise  = ~wr_n_d_r & wr_n_s;
  wire late_cap = receive_pointer_config[RPC_WLATE_POS];

  // Capture pulse: a fixed delay after the fall, or at the release
  wire early_hit = (wr_cnt_r == WR_CNT_W'(WR_EARLY_CYC));
  wire wr_cap = (st_r == ST_WRITE) &&
                (late_cap ? wr_rise : (early_hit | wr_rise));

  // Address phase decode for each bus width
  wire [7:0] addr16 = {lanes_hold_r[ADDR_HI_POS:ADDR_LO_POS], 2'b00};
  wire [3:0] be16   = lanes_hold_r[BE_HI_POS:BE_LO_POS];
  wire [7:0] addr8  = lanes_hold_r[7:0];
  // 8-bit mode is byte only: one enable picked by the low address bits
  wire [3:0] be8    = BE_BYTE0 << addr8[1:0];

  // Readback shows the latched address, and the enables only in 16-bit mode; 16-bit mode reads bits 11:8 and 1:0 as zero
  wire [15:0] addr_rb = bus_16bit ?
    {lane_en_r, 4'h0, addr_r[7:2], 2'b00} :
    {8'h00, addr_r};

  // Data steering: byte swap for big endian on a 16-bit bus; 8-bit writes replicate the byte, 8-bit reads pick it by addr_r[0]
  wire [15:0] wsw = big_endian ?
    {lanes_hold_r[7:0], lanes_hold_r[15:8]} : lanes_hold_r;
  wire [15:0] wdata_st = bus_16bit ? wsw :
    {lanes_hold_r[7:0], lanes_hold_r[7:0]};
  wire [15:0] rsw = big_endian ?
    {reg_rdata[7:0], reg_rdata[15:8]} : reg_rdata;
  wire [15:0] rdata_st = bus_16bit ? rsw :
    {8'h00, (addr_r[0] ? reg_rdata[15:8] : reg_rdata[7:0])};

  // Strap wins when pulled up; otherwise the config bit decides
  assign big_endian = strap_r |
    receive_pointer_config[RPC_ENDIAN_POS];

  // Next-state logic for one strobe at a time
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (wr_fall) begin
          st_nxt = ST_WRITE;
        end else if (rd_fall) begin
          st_nxt = cmd_s ? ST_RD_HOLD : ST_RD_FETCH;
        end
      end
      ST_WRITE: begin
        if (wr_cap) begin
          st_nxt = wr_n_s ? ST_IDLE : ST_WR_REL;
        end
      end
      ST_WR_REL: begin
        if (wr_n_s) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RD_FETCH: begin
        st_nxt = ST_RD_HOLD;
      end
      ST_RD_HOLD: begin
        if (rd_rise | rd_n_s) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // State, strobe history and write delay counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r     <= ST_IDLE;
      rd_n_d_r <= 1'b1;
      wr_n_d_r <= 1'b1;
      wr_cnt_r <= '0;
    end else begin
      st_r     <= st_nxt;
      rd_n_d_r <= rd_n_s;
      wr_n_d_r <= wr_n_s;
      wr_cnt_r <= (st_r == ST_WRITE && !early_hit) ?
                  wr_cnt_r + 1'b1 : '0;
    end
  end

  // Phase type is frozen at the strobe fall for the whole access
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cmd_lat_r <= 1'b0;
    end else if (wr_fall | rd_fall) begin
      cmd_lat_r <= cmd_s;
    end
  end

  // Address register: loaded by an address-phase write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      addr_r    <= ADDR_RST;
      lane_en_r <= BE_RST;
    end else if (wr_cap && cmd_lat_r) begin
      addr_r    <= bus_16bit ? addr16 : addr8;
      lane_en_r <= bus_16bit ? be16 : be8;
    end
  end

  // Data-phase write: registered pulse with steered data
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_pulse_r <= 1'b0;
      wdata_r    <= DATA_RST;
    end else begin
      wr_pulse_r <= wr_cap && !cmd_lat_r;
      if (wr_cap && !cmd_lat_r) begin
        wdata_r <= wdata_st;
      end
    end
  end

  // Reads: fetch pulse, then the data stays put until the strobe rises
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_pulse_r <= 1'b0;
      rd_data_r  <= DATA_RST;
    end else begin
      rd_pulse_r <= (st_r == ST_IDLE) && rd_fall && !cmd_s;
      if (st_r == ST_IDLE && rd_fall && cmd_s) begin
        rd_data_r <= addr_rb;
      end else if (st_r == ST_RD_FETCH) begin
        rd_data_r <= rdata_st;
      end
    end
  end

  // Strap is caught once, after reset is released
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      strap_r       <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_r       <= endian_strap;
      strap_taken_r <= 1'b1;
    end
  end

  // Interrupt pin follows the pending condition
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= ~irq_pending;
    end
  end

  // Lanes driven only while a selected read is in its hold phase
  assign shared_bus_oe_n = !(st_r == ST_RD_HOLD && !rd_n_s && !cs_n_s);
  assign shared_bus_out  = rd_data_r;
  assign reg_addr        = addr_r;
  assign reg_lane_en     = lane_en_r;
  assign reg_wr_pulse    = wr_pulse_r;
  assign reg_wdata       = wdata_r;
  assign reg_rd_pulse    = rd_pulse_r;

  // Checks
  property p_addr16;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cap && cmd_lat_r && bus_16bit |=>
      addr_r == {$past(lanes_hold_r[7:2]), 2'b00} &&
      lane_en_r == $past(lanes_hold_r[15:12]);
  endproperty
  a_addr16: assert property (p_addr16) else $error("addr16 load");
  property p_addr8;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cap && cmd_lat_r && !bus_16bit |=>
      addr_r == $past(lanes_hold_r[7:0]);
  endproperty
  a_addr8: assert property (p_addr8) else $error("addr8 load");
  property p_wr_data;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_cap && !cmd_lat_r |=> reg_wr_pulse ##1 !reg_wr_pulse;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write pulse");
  property p_cs_gate;
    @(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_IDLE && cs_n_s |=> st_r == ST_IDLE;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("cs ignored");
  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    irq_pending [*2] |-> !irq_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not low");
  property p_rd_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_RD_HOLD && $past(st_r) == ST_RD_HOLD |->
      $stable(shared_bus_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_early;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_fall && st_r == ST_IDLE && !late_cap && !cs_n_s
      ##1 (!wr_n_s && !late_cap) [*6] |-> wr_cap;
  endproperty
  a_early: assert property (p_early) else $error("early capture");
  property p_strap;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(strap_taken_r) |-> strap_r == $past(endian_strap);
  endproperty
  a_strap: assert property (p_strap) else $error("strap sample");
  property p_readback;
    @(posedge sys_clk) disable iff (!rst_n)
    st_r == ST_IDLE && rd_fall && cmd_s |=> shared_bus_out == $past(addr_rb);
  endproperty
  a_readback: assert property (p_readback) else $error("readback");
  property p_byte8;
    @(posedge sys_clk) disable iff (!rst_n)
    !bus_16bit && reg_wr_pulse |-> $onehot(reg_lane_en);
  endproperty
  a_byte8: assert property (p_byte8) else $error("8-bit not byte");
  c_addr_wr: cover property (@(posedge sys_clk) wr_cap && cmd_lat_r);
  c_data_wr: cover property (@(posedge sys_clk) reg_wr_pulse);
  c_data_rd: cover property (@(posedge sys_clk) reg_rd_pulse ##2 !shared_bus_oe_n);
  c_big: cover property (@(posedge sys_clk) reg_wr_pulse && big_endian);

endmodule
`default_nettype wire

// ---- design/host_bus_pkg.sv ----
// Constants and types shared by the host bus unit and its input stage
// Functional notes
// - 16-bit address phase: address 7:2, enables 15:12
// - Data phase: all sixteen lanes carry data; in 8-bit mode only lanes 7:0 are used
// - 8-bit address phase: address on lanes 7:0
// - Strobes ignored while chip select is high
// - Interrupt output low while condition pending
// - Read data held valid until strobe rises
// - Write capture pulse timing chosen by bit 12
// - 16-bit mode byte or word, 8-bit byte only
// - Byte lanes steered inside, no external swap
// - Endian strap: low little, high big endian
// - Bit 11 selects endian when strap low
// - Address phase write loads address and enables
// - Data phase reads or writes addressed register
// - Address phase read returns latched address
// - Single and burst transfers, byte or word
// - Internal logic runs from the reference clock; here it runs from sys_clk at 250 MHz
package host_bus_pkg;

  localparam int unsigned SYS_CLK_MHZ   = 250;
  localparam int unsigned REF_CLK_MHZ   = 25;
  // Early write capture delay after the strobe falls, in ns
  localparam int unsigned WR_EARLY_NS   = 20;
  localparam int unsigned WR_EARLY_CYC  =
    (WR_EARLY_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned WR_CNT_W      = 4;

  localparam int unsigned LANES         = 16;
  localparam int unsigned ADDR_LO_POS   = 2;
  localparam int unsigned ADDR_HI_POS   = 7;
  localparam int unsigned BE_LO_POS     = 12;
  localparam int unsigned BE_HI_POS     = 15;
  localparam int unsigned RPC_ENDIAN_POS = 11;
  localparam int unsigned RPC_WLATE_POS  = 12;

  localparam logic [7:0]  ADDR_RST      = 8'h00;
  localparam logic [3:0]  BE_RST        = 4'h0;
  localparam logic [15:0] DATA_RST      = 16'h0000;
  localparam logic [3:0]  BE_BYTE0      = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WRITE,
    ST_WR_REL,
    ST_RD_FETCH,
    ST_RD_HOLD
  } bus_state_e;

endpackage

// ---- design/strobe_sync.sv ----
// Two-stage synchroniser for the asynchronous host control inputs
`timescale 1ns/1ps
`default_nettype none
module strobe_sync
  import host_bus_pkg::*;
#(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             sys_clk,  // System clock
  input  wire logic             rst_n,    // Sync reset, active low
  input  wire logic [WIDTH-1:0] async_in, // Raw pin levels
  input  wire logic [WIDTH-1:0] rst_val,  // Level held during reset
  output logic      [WIDTH-1:0] sync_out  // Synchronised levels
);

  // First stage feeds only the second stage, one pair per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic stab_r;
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          meta_r <= rst_val[i];
          stab_r <= rst_val[i];
        end else begin
          meta_r <= async_in[i];
          stab_r <= meta_r;
        end
      end
      assign sync_out[i] = stab_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- bench/host_bus_model.sv ----
// Host processor model driving asynchronous cycles on the shared lanes
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input  wire logic        sys_clk,         // System clock
  input  wire logic        bus_16bit,       // Bus width in use
  output logic             select_n,        // Chip select
  output logic             cmd_type,        // Address or data phase
  output logic             read_strobe_n,   // Read strobe
  output logic             write_strobe_n,  // Write strobe
  output logic      [15:0] shared_bus_in,   // Lanes driven by host
  input  wire logic [15:0] shared_bus_out,  // Lanes driven by device
  input  wire logic        shared_bus_oe_n  // Device drive enable
);
  logic [15:0] lane_mask;

  // Upper lanes stay low on a narrow bus
  assign lane_mask = bus_16bit ? 16'hFFFF : 16'h00FF;

  initial begin
    select_n = 1'b1;
    cmd_type = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    shared_bus_in = 16'h0000;
  end

  // One cycle: strobe held, sampled at a rising edge, then the host inverts the lanes
  task automatic access(input logic sel, input logic wr, input logic cmd,
                        input logic [15:0] d, input int hold,
                        output logic [15:0] q);
    @(negedge sys_clk);
    select_n = sel;
    cmd_type = cmd;
    shared_bus_in = (wr ? d : ~d) & lane_mask;
    read_strobe_n = wr;
    write_strobe_n = !wr;
    repeat (hold) @(posedge sys_clk);
    // Undriven lanes show what the host itself left on them
    q = (shared_bus_oe_n === 1'b0) ? shared_bus_out : shared_bus_in;
    @(negedge sys_clk);
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    select_n = 1'b1;
    shared_bus_in = ~shared_bus_in & lane_mask;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// ---- bench/shared_bus_host_interface_tb.sv ----
// Self-checking bench for the host bus unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %h seen %h", n, e, a); end end
module shared_bus_host_interface_tb;
  typedef struct packed {
    logic b16; logic [15:0] cfg, aph; logic [7:0] ea; logic [3:0] ee;
    logic [15:0] rb, dat, wexp, rdat, rexp, msk;
  } row_s;
  logic sys_clk, rst_n = 1'b0, bus_16bit = 1'b1, select_n, cmd_type;
  logic read_strobe_n, write_strobe_n, shared_bus_oe_n, endian_strap = 1'b0;
  logic [15:0] shared_bus_in, shared_bus_out, reg_wdata, q;
  logic [15:0] receive_pointer_config = 16'h0000, reg_rdata = 16'h0000;
  logic irq_pending = 1'b0, irq_out_n, big_endian, reg_wr_pulse, reg_rd_pulse;
  logic [7:0] reg_addr;
  logic [3:0] reg_lane_en;
  logic [15:0] wdat;
  int err_total, compares, wr_cnt, rd_cnt, n, m;
  row_s rows [4];
  row_s r;

  host_bus_unit i_host_bus_unit (.sys_clk(sys_clk), .rst_n(rst_n),
    .bus_16bit(bus_16bit), .select_n(select_n), .cmd_type(cmd_type),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .shared_bus_in(shared_bus_in), .shared_bus_out(shared_bus_out),
    .shared_bus_oe_n(shared_bus_oe_n), .endian_strap(endian_strap),
    .receive_pointer_config(receive_pointer_config),
    .irq_pending(irq_pending), .irq_out_n(irq_out_n),
    .big_endian(big_endian), .reg_addr(reg_addr),
    .reg_lane_en(reg_lane_en), .reg_wr_pulse(reg_wr_pulse),
    .reg_wdata(reg_wdata), .reg_rd_pulse(reg_rd_pulse),
    .reg_rdata(reg_rdata));
  host_bus_model i_host_bus_model (.sys_clk(sys_clk),
    .bus_16bit(bus_16bit), .select_n(select_n), .cmd_type(cmd_type),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .shared_bus_in(shared_bus_in), .shared_bus_out(shared_bus_out),
    .shared_bus_oe_n(shared_bus_oe_n));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Count register writes and reads; keep the data of the last write
  always @(posedge sys_clk) begin
    if (reg_wr_pulse === 1'b1) begin
      wr_cnt++;
      wdat = reg_wdata;
    end
    if (reg_rd_pulse === 1'b1) begin
      rd_cnt++;
    end
  end

  task automatic acc(input logic s, input logic w, input logic c,
                     input logic [15:0] d, input int h);
    i_host_bus_model.access(s, w, c, d, h, q);
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("MISMATCH watchdog exp done seen hang");
    report_and_stop();
  end

  initial begin
    // Lane one is set in 16-bit address phases; it never reaches reg_addr
    rows[0] = '{1, 16'h0000, 16'h3026, 8'h24, 4'h3, 16'h3024, 16'hA55A,
                16'hA55A, 16'h1234, 16'h1234, 16'hFFFF};
    rows[1] = '{1, 16'h0800, 16'hC0F2, 8'hF0, 4'hC, 16'hC0F0, 16'hBEEF,
                16'hEFBE, 16'h1234, 16'h3412, 16'hFFFF};
    rows[2] = '{0, 16'h0000, 16'h0041, 8'h41, 4'h2, 16'h0041, 16'h00C3,
                16'hC3C3, 16'h5A7E, 16'h005A, 16'h00FF};
    rows[3] = '{0, 16'h0800, 16'h0086, 8'h86, 4'h4, 16'h0086, 16'h0011,
                16'h1111, 16'h5A7E, 16'h007E, 16'h00FF};
    do_reset();
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      bus_16bit = r.b16;
      receive_pointer_config = 16'h0000;
      reg_rdata = r.rdat;
      acc(0, 1, 1, r.aph, 12);
      `CHK("addr", r.ea, reg_addr)
      `CHK("lane_en", r.ee, reg_lane_en)
      acc(0, 0, 1, r.aph, 8);
      `CHK("readback", r.rb & r.msk, q & r.msk)
      receive_pointer_config = r.cfg;
      n = wr_cnt;
      acc(0, 1, 0, r.dat, 12);
      `CHK("wdata", r.wexp, wdat)
      `CHK("wr_count", n + 1, wr_cnt)
      m = rd_cnt;
      acc(0, 0, 0, r.dat, 8);
      `CHK("rdata", r.rexp, q & r.msk)
      `CHK("rd_pulse", m + 1, rd_cnt)
      $display("row %0d done", i);
    end
    // Deselected strobes do nothing
    bus_16bit = 1'b1;
    receive_pointer_config = 16'h0000;
    n = wr_cnt;
    acc(1, 1, 0, 16'h1111, 12);
    `CHK("desel_wr", n, wr_cnt)
    acc(1, 0, 0, 16'h1111, 8);
    `CHK("desel_rd", 16'hEEEE, q)
    $display("deselect done");
    // Burst of data writes after one address phase
    acc(0, 1, 1, 16'h1052, 12);
    n = wr_cnt;
    acc(0, 1, 0, 16'h0102, 12);
    acc(0, 1, 0, 16'h0304, 12);
    `CHK("burst_cnt", n + 2, wr_cnt)
    `CHK("burst_data", 16'h0304, wdat)
    `CHK("burst_addr", 8'h50, reg_addr)
    $display("burst done");
    // Early capture lands while the strobe is low, late one after release
    for (int k = 0; k < 2; k++) begin
      receive_pointer_config = k ? 16'h1000 : 16'h0000;
      n = wr_cnt;
      fork
        acc(0, 1, 0, 16'h7777, 20);
        begin
          repeat (18) @(posedge sys_clk);
          m = wr_cnt;
        end
      join
      `CHK("cap_mid", n + 1 - k, m)
      `CHK("cap_end", n + 1, wr_cnt)
      `CHK("cap_data", 16'h7777, wdat)
    end
    $display("capture timing done");
    // Interrupt follows the pending condition
    @(negedge sys_clk);
    irq_pending = 1'b1;
    @(negedge sys_clk);
    `CHK("irq_on", 1'b0, irq_out_n)
    irq_pending = 1'b0;
    @(negedge sys_clk);
    `CHK("irq_off", 1'b1, irq_out_n)
    $display("irq done");
    // Strap high selects big endian with the config bit clear
    endian_strap = 1'b1;
    receive_pointer_config = 16'h0000;
    do_reset();
    reg_rdata = 16'h1234;
    acc(0, 1, 0, 16'hA55A, 12);
    `CHK("strap_wr", 16'h5AA5, wdat)
    `CHK("strap_be", 1'b1, big_endian)
    acc(0, 0, 0, 16'h0000, 8);
    `CHK("strap_rd", 16'h3412, q)
    $display("strap done");
    report_and_stop();
  end
endmodule
`default_nettype wire
